//--- design/aobc_top.sv
`timescale 1ns/1ps
module aobc_top #(
  parameter int QCHG0_CYCLES = aobc_pkg::QCHG0_CYC,
  parameter int QCHG1_CYCLES = aobc_pkg::QCHG1_CYC,
  parameter int QCHG2_CYCLES = aobc_pkg::QCHG2_CYC,
  parameter int QCHG3_CYCLES = aobc_pkg::QCHG3_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin-based bias control
  input wire logic general_io_pin_in,
  // playback path selections
  output logic [2:0] pos_output_pin_route_out,
  output logic [2:0] neg_output_pin_route_out,
  output logic playback_channel_swap_out,
  output logic [1:0] pos_pin_drive_out,
  output logic [1:0] neg_pin_drive_out,
  // reference
  output logic [1:0] reference_level_out,
  output logic reference_power_out,
  output logic reference_fast_charge_out,
  output logic high_swing_enable_out,
  // microphone bias
  output logic [1:0] microphone_bias_level_out,
  output logic microphone_bias_power_out
);
  localparam int CNT_W = $clog2(QCHG3_CYCLES + 1);

  // ==========================================
  // registers
  logic [7:0] sleep_cfg, ref_cfg, adc_cfg, out_cfg, out_drive, swap_cfg, bias_cfg, ctrl;
  logic [7:0] next_sleep_cfg, next_ref_cfg, next_adc_cfg, next_out_cfg;
  logic [7:0] next_out_drive, next_swap_cfg, next_bias_cfg, next_ctrl;
  logic aw_held, w_held;
  logic next_aw_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write, timer_busy, ref_pwr_q, next_ref_pwr, charge_start;
  logic [CNT_W-1:0] charge_load;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = a inside {aobc_pkg::ADDR_SLEEP_CFG, aobc_pkg::ADDR_REF_CFG, aobc_pkg::ADDR_ADC_CFG,
      aobc_pkg::ADDR_OUT_CFG, aobc_pkg::ADDR_OUT_DRIVE, aobc_pkg::ADDR_SWAP_CFG,
      aobc_pkg::ADDR_BIAS_CFG, aobc_pkg::ADDR_CTRL, aobc_pkg::ADDR_STATUS};
  endfunction

  // ==========================================
  // write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_awready = s_axi_awready;
    next_wready = s_axi_wready;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
      next_awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_wready = 1'b0;
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (addr_ok(aw_addr) && aw_addr != aobc_pkg::ADDR_STATUS) ?
                   aobc_pkg::RESP_OKAY : aobc_pkg::RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
  end

  // reserved codes are stored as written; decode below keeps them safe
  always_comb
  begin
    next_sleep_cfg = sleep_cfg;
    next_ref_cfg = ref_cfg;
    next_adc_cfg = adc_cfg;
    next_out_cfg = out_cfg;
    next_out_drive = out_drive;
    next_swap_cfg = swap_cfg;
    next_bias_cfg = bias_cfg;
    next_ctrl = ctrl;
    if (do_write && w_strb[0])
    begin
      case (aw_addr)
        aobc_pkg::ADDR_SLEEP_CFG: next_sleep_cfg = w_data[7:0];
        aobc_pkg::ADDR_REF_CFG: next_ref_cfg = w_data[7:0];
        aobc_pkg::ADDR_ADC_CFG: next_adc_cfg = w_data[7:0];
        aobc_pkg::ADDR_OUT_CFG: next_out_cfg = w_data[7:0];
        aobc_pkg::ADDR_OUT_DRIVE: next_out_drive = w_data[7:0];
        aobc_pkg::ADDR_SWAP_CFG: next_swap_cfg = w_data[7:0];
        aobc_pkg::ADDR_BIAS_CFG: next_bias_cfg = w_data[7:0];
        aobc_pkg::ADDR_CTRL: next_ctrl = w_data[7:0];
        default: next_ctrl = ctrl;
      endcase
    end
  end

  // ==========================================
  // read channel, answer one cycle after address
  always_comb
  begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = addr_ok(s_axi_araddr) ? aobc_pkg::RESP_OKAY : aobc_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        aobc_pkg::ADDR_SLEEP_CFG: next_rdata = {24'h00_0000, sleep_cfg};
        aobc_pkg::ADDR_REF_CFG: next_rdata = {24'h00_0000, ref_cfg};
        aobc_pkg::ADDR_ADC_CFG: next_rdata = {24'h00_0000, adc_cfg};
        aobc_pkg::ADDR_OUT_CFG: next_rdata = {24'h00_0000, out_cfg};
        aobc_pkg::ADDR_OUT_DRIVE: next_rdata = {24'h00_0000, out_drive};
        aobc_pkg::ADDR_SWAP_CFG: next_rdata = {24'h00_0000, swap_cfg};
        aobc_pkg::ADDR_BIAS_CFG: next_rdata = {24'h00_0000, bias_cfg};
        aobc_pkg::ADDR_CTRL: next_rdata = {24'h00_0000, ctrl};
        aobc_pkg::ADDR_STATUS: next_rdata = {29'h0000_0000, microphone_bias_power_out,
                                             reference_fast_charge_out, reference_power_out};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sleep_cfg <= aobc_pkg::RST_SLEEP_CFG;
      ref_cfg <= aobc_pkg::RST_REF_CFG;
      adc_cfg <= aobc_pkg::RST_ADC_CFG;
      out_cfg <= aobc_pkg::RST_OUT_CFG;
      out_drive <= aobc_pkg::RST_OUT_DRIVE;
      swap_cfg <= aobc_pkg::RST_SWAP_CFG;
      bias_cfg <= aobc_pkg::RST_BIAS_CFG;
      ctrl <= aobc_pkg::RST_CTRL;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aobc_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= aobc_pkg::RESP_OKAY;
    end
    else
    begin
      sleep_cfg <= next_sleep_cfg;
      ref_cfg <= next_ref_cfg;
      adc_cfg <= next_adc_cfg;
      out_cfg <= next_out_cfg;
      out_drive <= next_out_drive;
      swap_cfg <= next_swap_cfg;
      bias_cfg <= next_bias_cfg;
      ctrl <= next_ctrl;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ==========================================
  // decode of the selections
  logic [2:0] src, mode, pos_route, neg_route, next_pos_route, next_neg_route;
  logic [1:0] ref_sel, bias_sel, next_ref_level, next_bias_level;
  logic next_bias_pwr, powered_down;
  assign src = out_cfg[aobc_pkg::SRC_LSB +: 3];
  assign mode = out_cfg[aobc_pkg::MODE_LSB +: 3];
  assign ref_sel = ref_cfg[aobc_pkg::REF_LSB +: 2];
  assign bias_sel = ref_cfg[aobc_pkg::BIAS_LSB +: 2];
  assign powered_down = ctrl[aobc_pkg::CTRL_SLEEP_BIT] | ctrl[aobc_pkg::CTRL_SHDN_BIT];

  always_comb
  begin
    // source per pin before the pin mode is applied
    pos_route = aobc_pkg::ROUTE_OFF;
    neg_route = aobc_pkg::ROUTE_OFF;
    case (src)
      aobc_pkg::SRC_OFF: pos_route = aobc_pkg::ROUTE_OFF;
      aobc_pkg::SRC_DAC: {pos_route, neg_route} = {aobc_pkg::ROUTE_DAC, aobc_pkg::ROUTE_DAC};
      aobc_pkg::SRC_BYP: {pos_route, neg_route} = {aobc_pkg::ROUTE_BYP, aobc_pkg::ROUTE_BYP};
      aobc_pkg::SRC_MIX: {pos_route, neg_route} = {aobc_pkg::ROUTE_MIX, aobc_pkg::ROUTE_MIX};
      aobc_pkg::SRC_DAC_BYP: {pos_route, neg_route} = {aobc_pkg::ROUTE_DAC, aobc_pkg::ROUTE_BYP};
      aobc_pkg::SRC_BYP_DAC: {pos_route, neg_route} = {aobc_pkg::ROUTE_BYP, aobc_pkg::ROUTE_DAC};
      default: pos_route = aobc_pkg::ROUTE_OFF;
    endcase
    next_pos_route = pos_route;
    next_neg_route = neg_route;
    case (mode)
      aobc_pkg::MODE_DIFF, aobc_pkg::MODE_DUAL: next_pos_route = pos_route;
      aobc_pkg::MODE_POS: next_neg_route = aobc_pkg::ROUTE_OFF;
      aobc_pkg::MODE_NEG: next_pos_route = aobc_pkg::ROUTE_OFF;
      aobc_pkg::MODE_PSD_POS:
        next_neg_route = (pos_route == aobc_pkg::ROUTE_OFF) ? aobc_pkg::ROUTE_OFF : aobc_pkg::ROUTE_CM;
      aobc_pkg::MODE_PSD_NEG:
        next_pos_route = (neg_route == aobc_pkg::ROUTE_OFF) ? aobc_pkg::ROUTE_OFF : aobc_pkg::ROUTE_CM;
      default:
      begin
        next_pos_route = aobc_pkg::ROUTE_OFF;
        next_neg_route = aobc_pkg::ROUTE_OFF;
      end
    endcase
    // reserved reference code falls back to the lowest level
    next_ref_level = (ref_sel == 2'h3) ? 2'h2 : ref_sel;
    case (bias_sel)
      2'h0: next_bias_level = aobc_pkg::BLVL_REF;
      2'h1: next_bias_level = ref_sel[1] ? aobc_pkg::BLVL_OFF : aobc_pkg::BLVL_HALF;
      2'h3: next_bias_level = aobc_pkg::BLVL_SUPPLY;
      default: next_bias_level = aobc_pkg::BLVL_OFF;
    endcase
    if (bias_sel == 2'h0 && ref_sel == 2'h3)
      next_bias_level = aobc_pkg::BLVL_OFF;
    // pin override wins over the software bit
    next_bias_pwr = ctrl[aobc_pkg::CTRL_PIN_BIAS_BIT] ? general_io_pin_in
                    : bias_cfg[aobc_pkg::BIAS_PWR_BIT];
    // reference off in sleep or shutdown; needs the sleep-exit enable
    next_ref_pwr = !powered_down && sleep_cfg[aobc_pkg::EXIT_REF_BIT];
    charge_start = next_ref_pwr && !ref_pwr_q;
    case (sleep_cfg[aobc_pkg::QCHG_LSB +: 2])
      2'h0: charge_load = CNT_W'(QCHG0_CYCLES);
      2'h1: charge_load = CNT_W'(QCHG1_CYCLES);
      2'h2: charge_load = CNT_W'(QCHG2_CYCLES);
      default: charge_load = CNT_W'(QCHG3_CYCLES);
    endcase
  end

  aobc_charge_timer #(
    .CNT_W(CNT_W)
  ) u_charge (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .start_in(charge_start),
    .abort_in(!next_ref_pwr),
    .load_in(charge_load),
    .busy_out(timer_busy)
  );

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pos_output_pin_route_out <= aobc_pkg::ROUTE_OFF;
      neg_output_pin_route_out <= aobc_pkg::ROUTE_OFF;
      playback_channel_swap_out <= 1'b0;
      pos_pin_drive_out <= 2'h0;
      neg_pin_drive_out <= 2'h0;
      reference_level_out <= 2'h0;
      reference_power_out <= 1'b0;
      ref_pwr_q <= 1'b0;
      reference_fast_charge_out <= 1'b0;
      high_swing_enable_out <= 1'b0;
      microphone_bias_level_out <= aobc_pkg::BLVL_OFF;
      microphone_bias_power_out <= 1'b0;
    end
    else
    begin
      pos_output_pin_route_out <= next_pos_route;
      neg_output_pin_route_out <= next_neg_route;
      playback_channel_swap_out <= swap_cfg[aobc_pkg::SWAP_BIT];
      pos_pin_drive_out <= out_drive[aobc_pkg::POS_DRV_LSB +: 2];
      neg_pin_drive_out <= out_drive[aobc_pkg::NEG_DRV_LSB +: 2];
      reference_level_out <= next_ref_level;
      reference_power_out <= next_ref_pwr;
      ref_pwr_q <= next_ref_pwr;
      reference_fast_charge_out <= timer_busy && next_ref_pwr;
      high_swing_enable_out <= adc_cfg[aobc_pkg::SWING_BIT];
      microphone_bias_level_out <= next_bias_level;
      microphone_bias_power_out <= next_bias_pwr;
    end
  end
endmodule

//--- common/aobc_pkg.sv
// Operation
// - source 000 off, 001 dac (reset), 010 bypass, 011 dac and bypass mix
// - source 100 dac on pos pin, 101 swapped; 11x reserved
// - channel swap bit exchanges the two playback channels
// - pin mode 000 differential (reset), 001 dual single-ended, 010 pos, 011 neg
// - mode 100 pseudo-diff pos signal, 110 neg signal; 101 and 111 reserved
// - each output pin has its own two-bit drive field
// - reference select 00 2.75V (reset), 01 2.5V, 10 1.375V, 11 reserved
// - full-scale bit set enables high-swing mode
// - reference block powered down in sleep or software shutdown
// - quick-charge field picks 3.5, 10, 50 or 100 ms fast charge
// - bias value 00 makes bias equal to selected reference
// - bias value 01 gives half reference, only with reference 00 or 01
// - bias value 10 reserved; 11 gives analog supply
// - bias power bit turns bias on; off at reset
// - when a pin controls bias, follow it and ignore the power bit
package aobc_pkg;
  // ==========================================
  // register byte addresses
  localparam logic [11:0] ADDR_SLEEP_CFG = 12'h0008;
  localparam logic [11:0] ADDR_REF_CFG = 12'h0134;
  localparam logic [11:0] ADDR_ADC_CFG = 12'h0140;
  localparam logic [11:0] ADDR_OUT_CFG = 12'h0190;
  localparam logic [11:0] ADDR_OUT_DRIVE = 12'h0194;
  localparam logic [11:0] ADDR_SWAP_CFG = 12'h01DC;
  localparam logic [11:0] ADDR_BIAS_CFG = 12'h01E0;
  localparam logic [11:0] ADDR_CTRL = 12'h0200;
  localparam logic [11:0] ADDR_STATUS = 12'h0204;
  // ==========================================
  // reset values
  localparam logic [7:0] RST_SLEEP_CFG = 8'h00;
  localparam logic [7:0] RST_REF_CFG = 8'h00;
  localparam logic [7:0] RST_ADC_CFG = 8'h00;
  localparam logic [7:0] RST_OUT_CFG = 8'h20;
  localparam logic [7:0] RST_OUT_DRIVE = 8'h00;
  localparam logic [7:0] RST_SWAP_CFG = 8'h00;
  localparam logic [7:0] RST_BIAS_CFG = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // ==========================================
  // field positions
  localparam int SRC_LSB = 5;
  localparam int MODE_LSB = 2;
  localparam int POS_DRV_LSB = 6;
  localparam int NEG_DRV_LSB = 4;
  localparam int REF_LSB = 0;
  localparam int BIAS_LSB = 2;
  localparam int SWING_BIT = 1;
  localparam int EXIT_REF_BIT = 3;
  localparam int QCHG_LSB = 4;
  localparam int SWAP_BIT = 0;
  localparam int BIAS_PWR_BIT = 5;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_SHDN_BIT = 1;
  localparam int CTRL_PIN_BIAS_BIT = 2;
  // ==========================================
  // clock and quick-charge times
  localparam int CLK_HZ = 20_000_000;
  localparam int QCHG0_US = 3500;
  localparam int QCHG1_US = 10000;
  localparam int QCHG2_US = 50000;
  localparam int QCHG3_US = 100000;
  localparam int QCHG0_CYC = QCHG0_US * (CLK_HZ / 1_000_000);
  localparam int QCHG1_CYC = QCHG1_US * (CLK_HZ / 1_000_000);
  localparam int QCHG2_CYC = QCHG2_US * (CLK_HZ / 1_000_000);
  localparam int QCHG3_CYC = QCHG3_US * (CLK_HZ / 1_000_000);
  // ==========================================
  // decoded selections
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_DAC = 3'h1;
  localparam logic [2:0] SRC_BYP = 3'h2;
  localparam logic [2:0] SRC_MIX = 3'h3;
  localparam logic [2:0] SRC_DAC_BYP = 3'h4;
  localparam logic [2:0] SRC_BYP_DAC = 3'h5;
  localparam logic [2:0] MODE_DIFF = 3'h0;
  localparam logic [2:0] MODE_DUAL = 3'h1;
  localparam logic [2:0] MODE_POS = 3'h2;
  localparam logic [2:0] MODE_NEG = 3'h3;
  localparam logic [2:0] MODE_PSD_POS = 3'h4;
  localparam logic [2:0] MODE_PSD_NEG = 3'h6;
  // pin route codes
  localparam logic [2:0] ROUTE_OFF = 3'h0;
  localparam logic [2:0] ROUTE_DAC = 3'h1;
  localparam logic [2:0] ROUTE_BYP = 3'h2;
  localparam logic [2:0] ROUTE_MIX = 3'h3;
  localparam logic [2:0] ROUTE_CM = 3'h4;
  // bias level codes
  localparam logic [1:0] BLVL_OFF = 2'h0;
  localparam logic [1:0] BLVL_REF = 2'h1;
  localparam logic [1:0] BLVL_HALF = 2'h2;
  localparam logic [1:0] BLVL_SUPPLY = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- design/aobc_charge_timer.sv
`timescale 1ns/1ps
module aobc_charge_timer #(
  parameter int CNT_W = 21
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // control
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [CNT_W-1:0] load_in,
  // status
  output logic busy_out
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_busy;

  always_comb
  begin
    next_count = count;
    next_busy = busy_out;
    if (abort_in)
    begin
      next_count = '0;
      next_busy = 1'b0;
    end
    else if (start_in)
    begin
      next_count = load_in;
      next_busy = 1'b1;
    end
    else if (busy_out)
    begin
      if (count <= CNT_W'(1))
        next_busy = 1'b0;
      next_count = count - CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count <= '0;
      busy_out <= 1'b0;
    end
    else
    begin
      count <= next_count;
      busy_out <= next_busy;
    end
  end
endmodule

//--- test/aobc_monitor.sv
`timescale 1ns/1ps
module aobc_monitor #(
  parameter int QCHG3_CYCLES = 80
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // register bus
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // selections
  input wire logic [2:0] pos_output_pin_route_out,
  input wire logic [2:0] neg_output_pin_route_out,
  input wire logic [1:0] reference_level_out,
  input wire logic reference_power_out,
  input wire logic reference_fast_charge_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // ==========================================
  // fast-charge run length
  logic [31:0] fc_cnt;
  logic [31:0] next_fc_cnt;
  always_comb
  begin
    next_fc_cnt = reference_fast_charge_out ? fc_cnt + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      fc_cnt <= 32'h0000_0000;
    else
      fc_cnt <= next_fc_cnt;
  end
  // ==========================================
  // properties
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_answer;
    s_axi_rvalid && !s_axi_arready;
  endsequence
  property p_r_answer;
    s_ar_take |=> s_r_answer;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("late read answer");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read not held");
  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("rdata upper bits set");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write resp not held");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during resp");
  property p_ref_level;
    reference_level_out != 2'h3;
  endproperty
  a_ref_level: assert property (p_ref_level) else $error("reserved ref level");
  property p_route_range;
    pos_output_pin_route_out <= aobc_pkg::ROUTE_CM && neg_output_pin_route_out <= aobc_pkg::ROUTE_CM;
  endproperty
  a_route_range: assert property (p_route_range) else $error("undefined route code");
  property p_cm_pos;
    pos_output_pin_route_out == aobc_pkg::ROUTE_CM |->
      neg_output_pin_route_out != aobc_pkg::ROUTE_OFF && neg_output_pin_route_out != aobc_pkg::ROUTE_CM;
  endproperty
  a_cm_pos: assert property (p_cm_pos) else $error("pos cm without signal");
  property p_cm_neg;
    neg_output_pin_route_out == aobc_pkg::ROUTE_CM |->
      pos_output_pin_route_out != aobc_pkg::ROUTE_OFF && pos_output_pin_route_out != aobc_pkg::ROUTE_CM;
  endproperty
  a_cm_neg: assert property (p_cm_neg) else $error("neg cm without signal");
  property p_fc_start;
    $rose(reference_fast_charge_out) |-> reference_power_out;
  endproperty
  a_fc_start: assert property (p_fc_start) else $error("charge while ref off");
  property p_fc_len;
    fc_cnt <= QCHG3_CYCLES + 1;
  endproperty
  a_fc_len: assert property (p_fc_len) else $error("charge too long");
endmodule
bind aobc_top aobc_monitor #(.QCHG3_CYCLES(QCHG3_CYCLES)) mon_u (.core_clk_in, .rst_in, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pos_output_pin_route_out, .neg_output_pin_route_out, .reference_level_out,
  .reference_power_out, .reference_fast_charge_out);

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  // ==========================================
  // signals
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, gpio = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, swap_o, rpwr, fchg, swing_o, bpwr;
  logic [1:0] bresp, rresp, pdrv, ndrv, rlvl, blvl;
  logic [2:0] pos_r, neg_r;
  logic [31:0] rdata;
  logic [31:0] rng_state = 32'h09e8_0c08;
  int error_cnt = 0;
  int samples_checked = 0;

  always #25 core_clk_in = ~core_clk_in;

  // short charge counts keep the run brief
  aobc_top #(.QCHG0_CYCLES(20), .QCHG1_CYCLES(40), .QCHG2_CYCLES(60), .QCHG3_CYCLES(80)) dut_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .general_io_pin_in(gpio),
    .pos_output_pin_route_out(pos_r), .neg_output_pin_route_out(neg_r), .playback_channel_swap_out(swap_o),
    .pos_pin_drive_out(pdrv), .neg_pin_drive_out(ndrv), .reference_level_out(rlvl), .reference_power_out(rpwr),
    .reference_fast_charge_out(fchg), .high_swing_enable_out(swing_o), .microphone_bias_level_out(blvl),
    .microphone_bias_power_out(bpwr));

  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    rng_state ^= rng_state << 13;
    rng_state ^= rng_state >> 17;
    rng_state ^= rng_state << 5;
    return rng_state;
  endfunction

  function automatic logic [5:0] route_exp(input logic [2:0] s, input logic [2:0] m);
    logic [2:0] p;
    logic [2:0] q;
    p = (s == 3'h4) ? 3'h1 : (s == 3'h5) ? 3'h2 : s;
    q = (s == 3'h4) ? 3'h2 : (s == 3'h5) ? 3'h1 : s;
    if (s > 3'h5 || (m[2] && m[0])) return 6'h00;
    if (m == 3'h2) q = 3'h0;
    if (m == 3'h3) p = 3'h0;
    if (m == 3'h4) q = (p != 3'h0) ? 3'h4 : 3'h0;
    if (m == 3'h6) p = (q != 3'h0) ? 3'h4 : 3'h0;
    return {p, q};
  endfunction

  function automatic logic [1:0] bias_exp(input logic [1:0] v, input logic [1:0] r);
    if (v == 2'h0) return (r != 2'h3) ? 2'h1 : 2'h0;
    if (v == 2'h1) return (r < 2'h2) ? 2'h2 : 2'h0;
    return (v == 2'h3) ? 2'h3 : 2'h0;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf, input logic [1:0] er = 2'h0);
    int n = 0;
    @(posedge core_clk_in);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100)
    begin
      @(posedge core_clk_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        chk(bresp, er, "write resp");
        bready <= 1'b0;
        n = 1000;
      end
    end
    if (n != 1000) chk(1'h1, 1'h0, "write hang");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    int n = 0;
    @(posedge core_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100)
    begin
      @(posedge core_clk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        chk(rdata, ed, "read data");
        chk(rresp, er, "read resp");
        rready <= 1'b0;
        n = 1000;
      end
    end
    if (n != 1000) chk(1'h1, 1'h0, "read hang");
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    logic [31:0] x;
    logic [2:0] src, mode;
    logic [1:0] refb, bv;
    logic [3:0] drv;
    logic pw, pin;
    int n;
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    chk({pos_r, neg_r}, 6'h09, "reset routes");
    chk({swap_o, pdrv, ndrv, rlvl, rpwr, fchg, swing_o, bpwr}, 1'h0, "reset outs");
    rd(aobc_pkg::ADDR_OUT_CFG, 32'h0000_0020);
    rd(aobc_pkg::ADDR_REF_CFG, 32'h0000_0000);
    rd(aobc_pkg::ADDR_BIAS_CFG, 32'h0000_0000);
    rd(aobc_pkg::ADDR_SLEEP_CFG, 32'h0000_0000);
    // all codes first, then random
    for (int i = 0; i < 48; i++)
    begin
      x = rnd();
      src = (i < 8) ? i[2:0] : (i < 16) ? 3'h1 : x[2:0];
      mode = (i < 8) ? 3'h0 : (i < 16) ? i[2:0] : x[5:3];
      refb = (i < 16) ? i[1:0] : x[7:6];
      bv = (i < 16) ? i[3:2] : x[9:8];
      drv = x[15:12];
      pw = x[18] || i < 16;
      pin = x[19];
      gpio <= x[20];
      wr(aobc_pkg::ADDR_OUT_CFG, {src, mode, 2'h0});
      wr(aobc_pkg::ADDR_OUT_DRIVE, {drv, 4'h0});
      wr(aobc_pkg::ADDR_SWAP_CFG, {7'h00, x[16]});
      wr(aobc_pkg::ADDR_REF_CFG, {4'h0, bv, refb});
      wr(aobc_pkg::ADDR_ADC_CFG, {6'h00, x[17], 1'b0});
      wr(aobc_pkg::ADDR_BIAS_CFG, {2'h0, pw, 5'h00});
      wr(aobc_pkg::ADDR_CTRL, {5'h00, pin, 2'h0});
      repeat (2) @(posedge core_clk_in);
      chk({pos_r, neg_r}, route_exp(src, mode), "routes");
      chk({swing_o, swap_o}, x[17:16], "swap swing");
      chk({pdrv, ndrv}, drv, "drive");
      chk(rlvl, (refb == 2'h3) ? 2'h2 : refb, "ref level");
      chk(bpwr, pin ? x[20] : pw, "bias power");
      if (pin ? x[20] : pw) chk(blvl, bias_exp(bv, refb), "bias level");
      rd(aobc_pkg::ADDR_OUT_CFG, {24'h00_0000, src, mode, 2'h0});
    end
    // reference power cycles through sleep and shutdown
    for (int q = 0; q < 4; q++)
    begin
      wr(aobc_pkg::ADDR_CTRL, 8'h01 << (q % 2));
      repeat (2) @(posedge core_clk_in);
      chk(rpwr, 1'h0, "ref off");
      wr(aobc_pkg::ADDR_SLEEP_CFG, {2'h0, q[1:0], 4'h8});
      wr(aobc_pkg::ADDR_CTRL, 8'h00);
      n = 0;
      repeat (300)
      begin
        @(posedge core_clk_in);
        if (fchg === 1'b1) n++;
      end
      chk(rpwr, 1'h1, "ref on");
      chk(n >= 20 * q + 19 && n <= 20 * q + 21, 1'h1, "charge length");
    end
    rd(aobc_pkg::ADDR_STATUS, {29'h0000_0000, pw, 2'h1});
    rd(12'h300, 32'h0000_0000, aobc_pkg::RESP_SLVERR);
    wr(12'h3fc, 8'h55, 4'hf, aobc_pkg::RESP_SLVERR);
    wr(aobc_pkg::ADDR_STATUS, 8'hff, 4'hf, aobc_pkg::RESP_SLVERR);
    wr(aobc_pkg::ADDR_OUT_CFG, 8'h00, 4'h0);
    rd(aobc_pkg::ADDR_OUT_CFG, {24'h00_0000, src, mode, 2'h0});
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    error_cnt++;
    print_verdict();
  end
endmodule
